/* hw/cgl_consts.svh */
/*
 * constants for the controller glue logic: data-space addresses,
 * reset values and timing counts.
 * assumes a 10 MHz ref_clk; included by bare name.
 */
`ifndef CGL_CONSTS_SVH
`define CGL_CONSTS_SVH

// ----------------------------------------------------------------
// data-space map
// ----------------------------------------------------------------
`define CGL_RAM_LO        16'h2000
`define CGL_RAM_HI        16'h7FFF
`define CGL_ADDR_FIRST    16'h8000
`define CGL_ADDR_PHASE    16'h8001
`define CGL_ADDR_GAIN     16'h8002
`define CGL_ADDR_BLANK    16'h8003
`define CGL_ADDR_EXP_A    16'h8004
`define CGL_ADDR_EXP_B    16'h8005
`define CGL_ADDR_RADIO    16'h8006
`define CGL_ADDR_INTER    16'h8007
`define CGL_ADDR_STATUS   16'h8008

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CGL_LATCH_RST     8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CGL_CLK_NS        100
`define CGL_POR_MS        15
`define CGL_POR_CYC       ((`CGL_POR_MS * 1000000) / `CGL_CLK_NS)
`define CGL_BLINK_MS      250
`define CGL_BLINK_CYC     ((`CGL_BLINK_MS * 1000000) / `CGL_CLK_NS)
`define CGL_FLICK_MS      20
`define CGL_FLICK_CYC     ((`CGL_FLICK_MS * 1000000) / `CGL_CLK_NS)

`endif

/* hw/cgl_pkg.sv */
/*
 * types for the controller glue logic.
 * assumes cgl_consts.svh is compiled alongside.
 */
`default_nettype none

package cgl_pkg;
	// chip selects towards the flash and the ram
	typedef struct packed {
		logic flash_code;   // flash in code space
		logic flash_data;   // flash in data space
		logic ram_code;     // ram in code space
		logic ram_data;     // ram in data space
	} cgl_mem_sel_s;

	// front panel indicators
	typedef struct packed {
		logic red;          // error indicator
		logic green;        // ready indicator
	} cgl_leds_s;

	// reset sequencer states
	typedef enum logic [1:0] {
		CGL_ST_POWER,
		CGL_ST_HOLD,
		CGL_ST_DELAY,
		CGL_ST_RUN
	} cgl_rst_state_e;
endpackage : cgl_pkg

`default_nettype wire

/* hw/cgl_glue.sv */
/*
 * controller glue logic: bus demultiplex, address decode, memory swap,
 * boot-block guard, reset combiner, oscillator gate, indicators.
 * assumes all inputs synchronous to ref_clk, microcontroller on the
 * multiplexed bus; the flash itself honours the write gate.
 */
//----------------------------------------------------------------
// Overview of operation
// - eight data, sixteen address bits fully decoded
// - low address byte latched on strobe
// - code by fetch strobe, data by rd/wr
// - normal code space maps to flash
// - swap select puts ram in code space
// - data 0x2000..0x7FFF selects ram unless swapped
// - 0x8000..0x8002 select the three converter latches
// - 0x8004, 0x8005 select the expander
// - 0x8006 radio latch, 0x8007 intermediate latch
// - flash has four separately erasable blocks
// - boot block writes need protect jumper
// - reset held about 15 ms after power-up
// - reset from switch, wake-up or pulse
// - pulse holds controller reset whole acquisition
// - external clock stops during pulse, reset delayed after
// - blank control masks pulse reset and clock stop
// - serial data ignored while booting
// - transmit outputs float after each transmission
// - green flickers on command until acknowledged
// - error state: red on, green off
// - blank: red blinks; pulse held: both on
// - software clock stop ends only by reset
//----------------------------------------------------------------
`include "cgl_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module cgl_glue
	import cgl_pkg::*;
#(
	parameter int POR_CYC   = `CGL_POR_CYC,   // power monitor delay
	parameter int BLINK_CYC = `CGL_BLINK_CYC, // red blink half period
	parameter int FLICK_CYC = `CGL_FLICK_CYC  // green flicker length
) (
	input  wire logic        ref_clk,            // 10 MHz clock
	input  wire logic        reset,              // sync reset, high
	input  wire logic [7:0]  ad_in,              // port 0 address/data in
	output logic      [7:0]  ad_out,             // port 0 read data
	output logic             ad_oe,              // port 0 drive enable
	input  wire logic [7:0]  addr_hi,            // high address byte
	input  wire logic        ale,                // address latch strobe
	input  wire logic        code_fetch_strobe_n,// code fetch strobe
	input  wire logic        rd_n,               // data read strobe
	input  wire logic        wr_n,               // data write strobe
	input  wire logic        memory_swap_select_n,// swap when low
	input  wire logic [16:0] flash_page_addr,    // flash address incl page
	input  wire logic        boot_protect_jumper,// high when fitted
	input  wire logic        manual_reset_n,     // reset switch
	input  wire logic        serial_wakeup_n,    // bus master wake-up
	input  wire logic        acq_pulse_in_n,     // acquisition pulse
	input  wire logic        soft_clock_stop,    // software clock stop
	input  wire logic        internal_osc,       // internal osc fitted
	input  wire logic        cmd_received,       // command seen, pulse
	input  wire logic        cmd_ack,            // command acked, pulse
	input  wire logic        fw_error,           // firmware error level
	input  wire logic        tx_done,            // transmission ended
	input  wire logic        tx_start,           // transmission begins
	input  wire logic [7:0]  exp_a_rd,           // expander port a
	input  wire logic [7:0]  exp_b_rd,           // expander port b
	output logic      [15:0] bus_addr,           // demultiplexed address
	output cgl_mem_sel_s     mem_sel,            // memory selects
	output logic             flash_we_ok,        // flash write allowed
	output logic      [1:0]  flash_block,        // block of flash addr
	output logic      [7:0]  first_dac_setting,  // first converter
	output logic      [7:0]  phase_dac_setting,  // phase converter
	output logic      [7:0]  gain_dac_setting,   // gain converter
	output logic      [7:0]  radio_control_driver, // radio latch
	output logic      [7:0]  intermediate_control_driver, // if latch
	output logic             exp_a_sel,          // expander port a
	output logic             exp_b_sel,          // expander port b
	output logic      [7:0]  exp_wr_data,        // expander data
	output logic             acq_blank_ctrl,     // blank mode
	output logic             reset_out_n,        // controller reset
	output logic             osc_enable,         // oscillator gate
	output logic             serial_rx_enable,   // serial served
	output logic             tx_enable,          // transmit drive
	output cgl_leds_s        leds                // indicators
);
	//------------------------------------------------------------
	// address demultiplex and decode
	//------------------------------------------------------------
	logic [7:0]      addr_lo_r;   // latched low byte
	logic            swap;        // ram in code space
	logic            data_acc;    // rd or wr active
	logic            wr_acc;      // write strobe
	cgl_rst_state_e  rst_st_r;    // reset sequencer
	logic [31:0]     cnt_r;       // sequencer delay count
	logic            clk_stop_r;  // software clock stop held
	logic            pulse_act;   // pulse effective

	assign bus_addr = {addr_hi, addr_lo_r};
	assign swap     = ~memory_swap_select_n;
	assign data_acc = ~rd_n | ~wr_n;
	assign wr_acc   = ~wr_n;

	// code space: flash normally, ram while swapped
	assign mem_sel.flash_code = ~code_fetch_strobe_n & ~swap;
	assign mem_sel.ram_code   = ~code_fetch_strobe_n & swap;
	assign mem_sel.flash_data = data_acc & swap &
		(bus_addr < `CGL_RAM_LO);
	assign mem_sel.ram_data   = data_acc & ~swap &
		(bus_addr >= `CGL_RAM_LO) & (bus_addr <= `CGL_RAM_HI);

	// block 0 is the boot block; four blocks by top address bits
	assign flash_block = flash_page_addr[16:15];
	assign flash_we_ok = mem_sel.flash_data & wr_acc &
		((flash_block != 2'h0) | boot_protect_jumper);

	assign exp_a_sel   = data_acc & (bus_addr == `CGL_ADDR_EXP_A);
	assign exp_b_sel   = data_acc & (bus_addr == `CGL_ADDR_EXP_B);
	assign exp_wr_data = ad_in;

	// read-back: expander ports and own status
	assign ad_oe  = ~rd_n & (exp_a_sel | exp_b_sel |
		(bus_addr == `CGL_ADDR_STATUS) | (bus_addr == `CGL_ADDR_BLANK));
	assign ad_out = exp_a_sel ? exp_a_rd :
		exp_b_sel ? exp_b_rd :
		(bus_addr == `CGL_ADDR_BLANK) ? {7'h00, acq_blank_ctrl} :
		{5'h00, fw_error, pulse_act, serial_rx_enable};

	// low address byte captured while the strobe is high
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			addr_lo_r <= 8'h00;
		end else if (ale) begin
			addr_lo_r <= ad_in;
		end
	end

	//------------------------------------------------------------
	// peripheral latches
	//------------------------------------------------------------
	// written on the write strobe; all clear on reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			first_dac_setting           <= `CGL_LATCH_RST;
			phase_dac_setting           <= `CGL_LATCH_RST;
			gain_dac_setting            <= `CGL_LATCH_RST;
			radio_control_driver        <= `CGL_LATCH_RST;
			intermediate_control_driver <= `CGL_LATCH_RST;
			acq_blank_ctrl              <= 1'b0;
		end else if (wr_acc) begin
			case (bus_addr)
				`CGL_ADDR_FIRST: first_dac_setting <= ad_in;
				`CGL_ADDR_PHASE: phase_dac_setting <= ad_in;
				`CGL_ADDR_GAIN:  gain_dac_setting  <= ad_in;
				`CGL_ADDR_RADIO: radio_control_driver <= ad_in;
				`CGL_ADDR_INTER:
					intermediate_control_driver <= ad_in;
				`CGL_ADDR_BLANK: acq_blank_ctrl <= ad_in[0];
				default: ;
			endcase
		end
	end

	//------------------------------------------------------------
	// reset combiner and oscillator gate
	//------------------------------------------------------------
	logic any_src;   // an external reset source active

	// blank mode masks the acquisition pulse entirely
	assign pulse_act = ~acq_pulse_in_n & ~acq_blank_ctrl;
	// wake-up is driven by the bus master; we only obey it
	assign any_src = ~manual_reset_n | ~serial_wakeup_n
		| pulse_act;

	// sequencer: hold while any source, delay after release
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rst_st_r <= CGL_ST_POWER;
			cnt_r    <= 32'h0000_0000;
		end else begin
			case (rst_st_r)
				CGL_ST_POWER: begin
					// power monitor delay before first release
					if (cnt_r >= 32'(POR_CYC - 1)) begin
						// a source still active keeps reset held
						rst_st_r <= any_src ? CGL_ST_HOLD
							: CGL_ST_RUN;
						cnt_r    <= 32'h0000_0000;
					end else begin
						cnt_r <= cnt_r + 32'h0000_0001;
					end
				end
				CGL_ST_HOLD: begin
					cnt_r <= 32'h0000_0000;
					if (!any_src) begin
						rst_st_r <= CGL_ST_DELAY;
					end
				end
				CGL_ST_DELAY: begin
					if (any_src) begin
						rst_st_r <= CGL_ST_HOLD;
					end else if (cnt_r >= 32'(POR_CYC - 1)) begin
						rst_st_r <= CGL_ST_RUN;
					end else begin
						cnt_r <= cnt_r + 32'h0000_0001;
					end
				end
				CGL_ST_RUN: begin
					if (any_src) begin
						rst_st_r <= CGL_ST_HOLD;
					end
				end
				default: rst_st_r <= CGL_ST_POWER;
			endcase
		end
	end

	// reset held anywhere but run
	assign reset_out_n = (rst_st_r == CGL_ST_RUN);

	// software stop holds until a hardware reset begins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			clk_stop_r <= 1'b0;
		end else if (!reset_out_n) begin
			clk_stop_r <= 1'b0;
		end else if (soft_clock_stop && internal_osc) begin
			clk_stop_r <= 1'b1;
		end
	end

	// external oscillator stops for the pulse unless blanked
	assign osc_enable = ~(pulse_act & ~internal_osc) & ~clk_stop_r;

	// serial served only once booted
	assign serial_rx_enable = reset_out_n;

	//------------------------------------------------------------
	// transmit enable and indicators
	//------------------------------------------------------------
	logic        flick_r;   // command pending flicker
	logic [31:0] fcnt_r;    // flicker count
	logic        fph_r;     // flicker phase, green lit while high
	logic [31:0] bcnt_r;    // blink count
	logic        blink_r;   // blink phase

	// driver floats after each transmission
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tx_enable <= 1'b0;
		end else if (tx_start) begin
			tx_enable <= 1'b1;
		end else if (tx_done) begin
			tx_enable <= 1'b0;
		end
	end

	// flicker: a received command wins over a same-cycle ack
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flick_r <= 1'b0;
			fcnt_r  <= 32'h0000_0000;
			fph_r   <= 1'b0;
		end else if (cmd_received) begin
			flick_r <= 1'b1;
			fcnt_r  <= 32'h0000_0000;
			fph_r   <= 1'b0;  // start dark so a short command still shows
		end else if (cmd_ack) begin
			flick_r <= 1'b0;
		end else if (flick_r && fcnt_r >= 32'(FLICK_CYC - 1)) begin
			fcnt_r <= 32'h0000_0000;
			fph_r  <= ~fph_r;
		end else if (flick_r) begin
			fcnt_r <= fcnt_r + 32'h0000_0001;
		end
	end

	// blink toggles at a fixed half period
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bcnt_r  <= 32'h0000_0000;
			blink_r <= 1'b0;
		end else if (bcnt_r >= 32'(BLINK_CYC - 1)) begin
			bcnt_r  <= 32'h0000_0000;
			blink_r <= ~blink_r;
		end else begin
			bcnt_r <= bcnt_r + 32'h0000_0001;
		end
	end

	// priority: reset hold, error, blank, command, ready
	always_comb begin
		if (!reset_out_n) begin
			leds = '{red: 1'b1, green: 1'b1};
		end else if (fw_error) begin
			leds = '{red: 1'b1, green: 1'b0};
		end else if (acq_blank_ctrl) begin
			leds = '{red: blink_r, green: 1'b1};
		end else if (flick_r) begin
			leds = '{red: 1'b0, green: fph_r};
		end else begin
			leds = '{red: 1'b0, green: 1'b1};
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	a_ram_decode: assert property (@(posedge ref_clk) disable iff (reset)
		mem_sel.ram_data |-> (bus_addr >= 16'h2000 && bus_addr <= 16'h7FFF))
		else $error("ram selected outside its window");
	a_swap_code: assert property (@(posedge ref_clk) disable iff (reset)
		(~code_fetch_strobe_n & ~memory_swap_select_n) |->
		(mem_sel.ram_code & ~mem_sel.flash_code))
		else $error("swap did not route code to ram");
	a_boot_guard: assert property (@(posedge ref_clk) disable iff (reset)
		(flash_we_ok && flash_page_addr[16:15] == 2'h0) |->
		boot_protect_jumper)
		else $error("boot block written without jumper");
	a_addr_latch: assert property (@(posedge ref_clk) disable iff (reset)
		ale |=> bus_addr[7:0] == $past(ad_in))
		else $error("low address byte not captured");
	a_dac_write: assert property (@(posedge ref_clk) disable iff (reset)
		(wr_acc && bus_addr == 16'h8001) |=>
		phase_dac_setting == $past(ad_in))
		else $error("phase latch missed a write");
	sequence s_pulse_on;
		pulse_act;
	endsequence
	a_pulse_hold: assert property (@(posedge ref_clk) disable iff (reset)
		s_pulse_on ##1 pulse_act |-> !reset_out_n)
		else $error("reset not held during pulse");
	a_blank_mask: assert property (@(posedge ref_clk) disable iff (reset)
		(acq_blank_ctrl && !internal_osc && !clk_stop_r) |-> osc_enable)
		else $error("clock stopped in blank mode");
	a_rx_boot: assert property (@(posedge ref_clk) disable iff (reset)
		!reset_out_n |-> !serial_rx_enable)
		else $error("serial served while booting");
	a_err_leds: assert property (@(posedge ref_clk) disable iff (reset)
		(reset_out_n && fw_error) |-> (leds.red && !leds.green))
		else $error("error indicators wrong");
	a_tx_float: assert property (@(posedge ref_clk) disable iff (reset)
		(tx_done && !tx_start) |=> !tx_enable)
		else $error("transmitter left driving");
	a_flick_ack: assert property (@(posedge ref_clk) disable iff (reset)
		(cmd_ack && !cmd_received) |=> !flick_r)
		else $error("flicker not ended by ack");
	a_stop_reset: assert property (@(posedge ref_clk) disable iff (reset)
		!reset_out_n |=> !clk_stop_r)
		else $error("clock stop survived reset");
	a_release_delay: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(reset_out_n) |-> ($past(rst_st_r) != CGL_ST_HOLD &&
		$past(cnt_r) == 32'(POR_CYC - 1)))
		else $error("reset released without delay");
endmodule : cgl_glue

`default_nettype wire

/* verification/cgl_mcu_model.sv */
/*
 * behavioural model of the microcontroller on the multiplexed bus.
 * assumes the glue samples on the rising edge of ref_clk; the model
 * changes its lines on the falling edge only.
 */
`timescale 1ns/10ps
`default_nettype none

module cgl_mcu_model
	import cgl_pkg::*;
(
	input  wire logic         ref_clk,             // system clock
	output logic       [7:0]  ad_in,               // port 0 to glue
	output logic       [7:0]  addr_hi,             // high address byte
	output logic              ale,                 // address strobe
	output logic              code_fetch_strobe_n, // code fetch strobe
	output logic              rd_n,                // data read strobe
	output logic              wr_n,                // data write strobe
	input  wire logic  [7:0]  ad_out,              // read data
	input  wire logic         ad_oe,               // read drive enable
	input  wire cgl_mem_sel_s mem_sel              // memory selects
);
	// ----------------------------------------------------------------
	// idle bus
	// ----------------------------------------------------------------
	initial begin
		ad_in = 8'hFF;
		addr_hi = 8'h00;
		ale = 1'b0;
		code_fetch_strobe_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
	end

	// ----------------------------------------------------------------
	// one bus cycle: kind 0 write, 1 data read, 2 code fetch
	// ----------------------------------------------------------------
	// the port is never left showing the last byte, so a glue that
	// samples late sees garbage rather than a lucky match
	task automatic cycle(input logic [1:0] kind, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic oe,
		output cgl_mem_sel_s sel);
		@(negedge ref_clk);
		ale = 1'b1;
		addr_hi = a[15:8];
		ad_in = a[7:0];
		@(negedge ref_clk);
		ale = 1'b0;
		if (kind == 2'd0) begin
			wr_n = 1'b0;
			ad_in = d;
		end else begin
			ad_in = ~a[7:0];
			if (kind == 2'd1) begin
				rd_n = 1'b0;
			end else begin
				code_fetch_strobe_n = 1'b0;
			end
		end
		@(posedge ref_clk);
		q = ad_out;
		oe = ad_oe;
		sel = mem_sel;
		@(negedge ref_clk);
		wr_n = 1'b1;
		rd_n = 1'b1;
		code_fetch_strobe_n = 1'b1;
		ad_in = ~d;
	endtask : cycle
endmodule : cgl_mcu_model

`default_nettype wire

/* verification/testbench.sv */
/*
 * self-checking bench for the controller glue logic.
 * assumes the glue with short counts (POR 20, blink and flicker 8)
 * and the bus model in cgl_mcu_model.sv.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; \
	if ((got) !== (ex)) begin n_fail++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module testbench
	import cgl_pkg::*;
;
	localparam int POR = 20;           // shortened power monitor delay
	typedef struct packed {
		logic [15:0] a;                // latch address
		logic [7:0]  d;                // value written
		logic [2:0]  k;                // which latch output
	} cgl_row_s;
	logic ref_clk = 1'b0, reset = 1'b1;          // clock and reset
	logic [7:0] ad_in, addr_hi, ad_out, q;       // port 0 and high byte
	logic ale, code_fetch_strobe_n, rd_n, wr_n;  // bus strobes
	logic ad_oe, oe, flash_we_ok, acq_blank_ctrl;
	logic memory_swap_select_n = 1'b1, boot_protect_jumper = 1'b0;
	logic manual_reset_n = 1'b1, serial_wakeup_n = 1'b1;
	logic acq_pulse_in_n = 1'b1, soft_clock_stop = 1'b0;
	logic internal_osc = 1'b0, cmd_received = 1'b0, cmd_ack = 1'b0;
	logic fw_error = 1'b0, tx_done = 1'b0, tx_start = 1'b0;
	logic [16:0] flash_page_addr = 17'h1_0000;   // application block
	logic [15:0] bus_addr;                       // demultiplexed address
	logic [1:0] flash_block;                     // block of flash address
	logic [7:0] lat [5];                         // latch outputs
	logic exp_a_sel, exp_b_sel, reset_out_n, osc_enable;
	logic serial_rx_enable, tx_enable;
	logic [7:0] exp_wr_data;                     // expander write data
	cgl_mem_sel_s mem_sel, sel;                  // memory selects
	cgl_leds_s leds;                             // indicators
	int n_fail = 0, samples_checked = 0;         // error and check counts
	int n_we = 0, n_exp = 0;                     // flash gates, expander hits
	cgl_row_s rows [5] = '{'{16'h8000, 8'hA5, 3'd0},
		'{16'h8001, 8'h3C, 3'd1}, '{16'h8002, 8'hFF, 3'd2},
		'{16'h8006, 8'h81, 3'd3}, '{16'h8007, 8'h7E, 3'd4}};

	// ----------------------------------------------------------------
	// clock, model and design
	// ----------------------------------------------------------------
	always #50 ref_clk = ~ref_clk;   // 10 MHz

	// count strobe-wide selects at the edge where they stand
	always @(posedge ref_clk) begin
		if (flash_we_ok === 1'b1) n_we++;
		if (exp_a_sel === 1'b1 || exp_b_sel === 1'b1) n_exp++;
	end
	cgl_mcu_model MCU (.ref_clk(ref_clk), .ad_in(ad_in), .addr_hi(addr_hi),
		.ale(ale), .code_fetch_strobe_n(code_fetch_strobe_n), .rd_n(rd_n),
		.wr_n(wr_n), .ad_out(ad_out), .ad_oe(ad_oe), .mem_sel(mem_sel));
	cgl_glue #(.POR_CYC(POR), .BLINK_CYC(8), .FLICK_CYC(8)) DUT (
		.ref_clk(ref_clk), .reset(reset), .ad_in(ad_in), .ad_out(ad_out),
		.ad_oe(ad_oe), .addr_hi(addr_hi), .ale(ale),
		.code_fetch_strobe_n(code_fetch_strobe_n), .rd_n(rd_n), .wr_n(wr_n),
		.memory_swap_select_n(memory_swap_select_n),
		.flash_page_addr(flash_page_addr),
		.boot_protect_jumper(boot_protect_jumper),
		.manual_reset_n(manual_reset_n), .serial_wakeup_n(serial_wakeup_n),
		.acq_pulse_in_n(acq_pulse_in_n), .soft_clock_stop(soft_clock_stop),
		.internal_osc(internal_osc), .cmd_received(cmd_received),
		.cmd_ack(cmd_ack), .fw_error(fw_error), .tx_done(tx_done),
		.tx_start(tx_start), .exp_a_rd(8'h5A), .exp_b_rd(8'hC3),
		.bus_addr(bus_addr), .mem_sel(mem_sel), .flash_we_ok(flash_we_ok),
		.flash_block(flash_block), .first_dac_setting(lat[0]),
		.phase_dac_setting(lat[1]), .gain_dac_setting(lat[2]),
		.radio_control_driver(lat[3]), .intermediate_control_driver(lat[4]),
		.exp_a_sel(exp_a_sel), .exp_b_sel(exp_b_sel),
		.exp_wr_data(exp_wr_data), .acq_blank_ctrl(acq_blank_ctrl),
		.reset_out_n(reset_out_n), .osc_enable(osc_enable),
		.serial_rx_enable(serial_rx_enable), .tx_enable(tx_enable),
		.leds(leds));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic ticks(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : ticks

	// bounded wait for the controller to leave reset; returns cycles
	task automatic wait_run(output int n);
		n = 0;
		while (reset_out_n !== 1'b1 && n < POR + 10) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("run wait", 1'b1, reset_out_n)
	endtask : wait_run

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run

	// watchdog: the whole sequence needs well under 5000 cycles
	initial begin
		#(100 * 5000);
		n_fail++;
		complete_run();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		ticks(4);
		`CHK("latch rst", 8'h00, lat[0] | lat[3])
		`CHK("rst hold", 1'b0, reset_out_n)
		reset = 1'b0;
		ticks(POR - 4);
		`CHK("por early", 1'b0, reset_out_n)
		wait_run(n);
		`CHK("por ends", 1'b1, reset_out_n)
		`CHK("rx served", 1'b1, serial_rx_enable)
		// ordinary latch writes, back to back
		foreach (rows[i]) MCU.cycle(2'd0, rows[i].a, rows[i].d, q, oe, sel);
		ticks(1);
		foreach (rows[i]) `CHK("latch", rows[i].d, lat[rows[i].k])
		`CHK("addr", 16'h8007, bus_addr)
		// unmapped write leaves the intermediate latch alone
		MCU.cycle(2'd0, 16'h8009, 8'h00, q, oe, sel);
		ticks(1);
		`CHK("unmapped", 8'h7E, lat[4])
		MCU.cycle(2'd1, 16'h8004, 8'h00, q, oe, sel);
		`CHK("exp a", 9'h15A, {oe, q})
		MCU.cycle(2'd1, 16'h8005, 8'h00, q, oe, sel);
		`CHK("exp b", 9'h1C3, {oe, q})
		MCU.cycle(2'd1, 16'h8010, 8'h00, q, oe, sel);
		`CHK("no drive", 1'b0, oe)
		`CHK("exp sel", 2, n_exp)
		// memory map, normal and swapped
		MCU.cycle(2'd2, 16'h0100, 8'h00, q, oe, sel);
		`CHK("code flash", 2'b10, {sel.flash_code, sel.ram_code})
		MCU.cycle(2'd1, 16'h2000, 8'h00, q, oe, sel);
		`CHK("ram lo", 1'b1, sel.ram_data)
		MCU.cycle(2'd1, 16'h7FFF, 8'h00, q, oe, sel);
		`CHK("ram hi", 1'b1, sel.ram_data)
		memory_swap_select_n = 1'b0;
		MCU.cycle(2'd2, 16'h0100, 8'h00, q, oe, sel);
		`CHK("code ram", 2'b01, {sel.flash_code, sel.ram_code})
		MCU.cycle(2'd1, 16'h0100, 8'h00, q, oe, sel);
		`CHK("data flash", 1'b1, sel.flash_data)
		// boot block guarded without the jumper
		flash_page_addr = 17'h0_0100;
		MCU.cycle(2'd0, 16'h0100, 8'h11, q, oe, sel);
		`CHK("boot blk", 2'b00, flash_block)
		`CHK("boot guard", 0, n_we)
		boot_protect_jumper = 1'b1;
		MCU.cycle(2'd0, 16'h0100, 8'h11, q, oe, sel);
		`CHK("boot jumper", 1, n_we)
		boot_protect_jumper = 1'b0;
		flash_page_addr = 17'h1_0000;
		MCU.cycle(2'd0, 16'h0100, 8'h11, q, oe, sel);
		`CHK("app blk", 2'b10, flash_block)
		`CHK("app write", 2, n_we)
		memory_swap_select_n = 1'b1;
		// transmit enable and firmware error indicators
		tx_start = 1'b1;
		ticks(1);
		tx_start = 1'b0;
		ticks(1);
		`CHK("tx on", 1'b1, tx_enable)
		tx_done = 1'b1;
		ticks(1);
		tx_done = 1'b0;
		ticks(1);
		`CHK("tx off", 1'b0, tx_enable)
		fw_error = 1'b1;
		ticks(2);
		`CHK("err leds", 2'b10, leds)
		MCU.cycle(2'd1, 16'h8008, 8'h00, q, oe, sel);
		`CHK("status", 9'h105, {oe, q})
		fw_error = 1'b0;
		// command flicker, ended by the acknowledge
		cmd_received = 1'b1;
		ticks(1);
		cmd_received = 1'b0;
		`CHK("flick dark", 2'b00, leds)
		ticks(8);
		`CHK("flick lit", 2'b01, leds)
		cmd_ack = 1'b1;
		ticks(1);
		cmd_ack = 1'b0;
		ticks(9);
		`CHK("flick end", 2'b01, leds)
		// reset sources, acquisition pulse with external oscillator
		manual_reset_n = 1'b0;
		ticks(2);
		`CHK("switch", 2'b00, {reset_out_n, serial_rx_enable})
		manual_reset_n = 1'b1;
		wait_run(n);
		serial_wakeup_n = 1'b0;
		ticks(2);
		`CHK("wakeup", 1'b0, reset_out_n)
		serial_wakeup_n = 1'b1;
		wait_run(n);
		acq_pulse_in_n = 1'b0;
		ticks(5);
		`CHK("pulse", 4'b0011, {reset_out_n, osc_enable, leds})
		acq_pulse_in_n = 1'b1;
		ticks(2);
		`CHK("osc back", 2'b01, {reset_out_n, osc_enable})
		wait_run(n);
		`CHK("pulse rel", 1'b1, reset_out_n)
		// blank mode masks the pulse
		MCU.cycle(2'd0, 16'h8003, 8'h01, q, oe, sel);
		ticks(1);
		MCU.cycle(2'd1, 16'h8003, 8'h00, q, oe, sel);
		`CHK("blank rd", 9'h101, {oe, q})
		acq_pulse_in_n = 1'b0;
		ticks(5);
		`CHK("blank", 4'b1111, {acq_blank_ctrl, reset_out_n, osc_enable,
			leds.green})
		q[0] = leds.red;
		ticks(8);
		`CHK("blink", ~q[0], leds.red)
		acq_pulse_in_n = 1'b1;
		// software clock stop with internal oscillator
		internal_osc = 1'b1;
		soft_clock_stop = 1'b1;
		ticks(1);
		soft_clock_stop = 1'b0;
		ticks(5);
		`CHK("clk stop", 1'b0, osc_enable)
		manual_reset_n = 1'b0;
		ticks(2);
		manual_reset_n = 1'b1;
		wait_run(n);
		`CHK("clk back", 1'b1, osc_enable)
		// hardware reset clears latches and blank
		reset = 1'b1;
		ticks(2);
		reset = 1'b0;
		`CHK("clear", 10'h000, {acq_blank_ctrl, lat[0], reset_out_n})
		complete_run();
	end
endmodule : testbench

`default_nettype wire
